// *** inc/sssp_pkg.sv ***
package sssp_pkg;
   // register word offsets on the plain register port
   localparam logic [2:0] ADDR_BUFFER = 3'h0;
   localparam logic [2:0] ADDR_CONTROL_1 = 3'h1;
   localparam logic [2:0] ADDR_STATUS = 3'h2;
   localparam logic [2:0] ADDR_IRQ_FLAGS_1 = 3'h3;
   localparam logic [2:0] ADDR_IRQ_ENABLES_1 = 3'h4;
   localparam logic [2:0] ADDR_PIN_DIR = 3'h5;
   // port_mode_field encodings
   localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
   localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
   localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
   localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
   localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
   localparam logic [3:0] MODE_SLAVE_NOSS = 4'h5;
   // divider terminal counts: half sck period minus one, in clocks
   localparam logic [4:0] HALF_DIV4 = 5'h01;
   localparam logic [4:0] HALF_DIV16 = 5'h07;
   localparam logic [4:0] HALF_DIV64 = 5'h1F;
   // master half-period edge numbering
   localparam logic [4:0] EDGE_FIRST = 5'h01;
   localparam logic [4:0] EDGE_FIRST_LATE = 5'h03;
   localparam logic [4:0] EDGE_SCK_LAST = 5'h10;
   localparam logic [4:0] EDGE_LATE_LAST = 5'h11;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // bit positions
   localparam int unsigned PIF_BIT = 3;
   localparam int unsigned PIE_BIT = 3;
   localparam int unsigned SDO_IN_BIT = 0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   typedef struct packed {
      logic write_collision_flag;
      logic ovf;
      logic en;
      logic clock_polarity_bit;
      logic [3:0] mode;
   } sssp_ctrl_t;

   typedef struct packed {
      logic sample_phase_bit;
      logic cke;
   } sssp_stat_t;

   typedef struct packed {
      logic sck;
      logic sdi;
      logic ssN;
   } sssp_pins_t;

   localparam sssp_ctrl_t CTRL_RESET = '{default: 1'b0};
   localparam sssp_stat_t STAT_RESET = '{default: 1'b0};

   typedef enum logic {SSSP_IDLE, SSSP_SHIFT} sssp_state_t;
endpackage

// *** src/sssp_core.sv ***
// How it works
// - master starts on buffer write alone
// - sdo as input, master still receives
// - bytes shift msb first
// - master rate 4tcy, 16tcy, 64tcy, timer/2
// - mode 0,1,2 pick div 4,16,64
// - edge bit set, data before first edge
// - sample bit picks middle or end sampling
// - slave shifts on external clock, flags byte
// - slave runs and wakes during sleep
// - mode 4 is slave with select
// - select low drives sdo, enables shifting
// - select high floats sdo, even mid-byte, after the synchroniser delay
// - select high resets serial logic
// - serial reset zeroes bit counter
// - sdo as input stops transmit drive
// - master freezes in sleep, then resumes
// - wake only with interrupt enabled
// - slave completes after eight bits, wakes
// - device reset disables port, aborts transfer
// - spi modes map onto polarity, edge bits
// - busy write loads no data, sets collision flag; master sequencer start ignores busy
`timescale 1ns/1ps
`default_nettype none
module sssp_core
   import sssp_pkg::*;
#(
   parameter int unsigned SYNC_DEPTH = 2
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic sleepIn,
   input wire logic timerTick,
   input wire logic sckIn,
   output logic sckOut,
   output logic sckOe,
   input wire logic sdiIn,
   output logic sdoOut,
   output logic sdoOe,
   input wire logic ssNIn,
   output logic wakeOut
);
   // refuse a synchroniser that cannot settle metastability
   if (SYNC_DEPTH < 2) begin : g_bad_depth
      $error("SYNC_DEPTH must be at least 2");
   end

   function automatic logic isMaster(input logic [3:0] mode);
      isMaster = (mode == MODE_MASTER_DIV4) || (mode == MODE_MASTER_DIV16) ||
         (mode == MODE_MASTER_DIV64) || (mode == MODE_MASTER_TIMER);
   endfunction

   function automatic logic isSlave(input logic [3:0] mode);
      isSlave = (mode == MODE_SLAVE_SS) || (mode == MODE_SLAVE_NOSS);
   endfunction

   sssp_ctrl_t ctrl_q;
   sssp_stat_t stat_q;
   sssp_state_t state_q;
   logic [7:0] buffer_q;
   logic [7:0] txShift_q;
   logic [7:0] rxShift_q;
   logic [7:0] rxNext;
   logic bufFull_q;
   logic pif_q;
   logic pie_q;
   logic sdoIn_q;
   logic [2:0] bitCount_q;
   logic [4:0] divCount_q;
   logic [4:0] edge_q;
   logic sckPrev_q;
   logic [SYNC_DEPTH-1:0] mSampleDly_q;
   sssp_pins_t syncQ [SYNC_DEPTH];
   sssp_pins_t pins;

   // pin synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge clock) begin
      if (reset) begin
         syncQ[0] <= '{default: 1'b1};
      end else if (clkEn) begin
         syncQ[0] <= '{sck: sckIn, sdi: sdiIn, ssN: ssNIn};
      end
   end
   for (genvar s = 1; s < SYNC_DEPTH; s++) begin : g_sync
      always_ff @(posedge clock) begin
         if (reset) begin
            syncQ[s] <= '{default: 1'b1};
         end else if (clkEn) begin
            syncQ[s] <= syncQ[s-1];
         end
      end
   end
   assign pins = syncQ[SYNC_DEPTH-1];

   // decode of the current setup
   logic enabled;
   logic master;
   logic slave;
   logic ssHeld;
   logic serialReset;
   logic cke;
   logic sample_phase_bit;
   assign enabled = ctrl_q.en;
   assign master = enabled && isMaster(ctrl_q.mode);
   assign slave = enabled && isSlave(ctrl_q.mode);
   assign ssHeld = (ctrl_q.mode == MODE_SLAVE_SS) && pins.ssN;
   assign serialReset = !enabled || (slave && ssHeld);
   assign cke = stat_q.cke;
   assign sample_phase_bit = stat_q.sample_phase_bit;

   // software access decode
   logic bufWr;
   logic bufRd;
   logic busy;
   logic collide;
   assign bufWr = regWr && (regAddr == ADDR_BUFFER);
   assign bufRd = regRd && (regAddr == ADDR_BUFFER);
   assign busy = (state_q == SSSP_SHIFT) || (slave && (bitCount_q != 3'h0)) || (|mSampleDly_q);
   assign collide = bufWr && busy;

   // master bit clock: sleep stops the divider so a byte freezes mid-way
   logic halfTick;
   logic [4:0] halfLimit;
   always_comb begin
      case (ctrl_q.mode)
         MODE_MASTER_DIV16: halfLimit = HALF_DIV16;
         MODE_MASTER_DIV64: halfLimit = HALF_DIV64;
         default: halfLimit = HALF_DIV4;
      endcase
   end
   always_comb begin
      if (state_q != SSSP_SHIFT || sleepIn) begin
         halfTick = 1'b0;
      end else if (ctrl_q.mode == MODE_MASTER_TIMER) begin
         halfTick = timerTick;
      end else begin
         halfTick = (divCount_q == halfLimit);
      end
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         divCount_q <= 5'h00;
      end else if (clkEn) begin
         if (state_q != SSSP_SHIFT || halfTick) begin
            divCount_q <= 5'h00;
         end else if (!sleepIn) begin
            divCount_q <= divCount_q + 5'h01;
         end
      end
   end

   // master edge classes; edge n ends half period n
   logic [4:0] nextEdge;
   logic oddEdge;
   logic mOutEdge;
   logic mSampleEdge;
   logic mLastEdge;
   assign nextEdge = edge_q + 5'h01;
   assign oddEdge = nextEdge[0];
   assign mOutEdge = halfTick && (nextEdge < EDGE_SCK_LAST) &&
      (cke ? !oddEdge : (oddEdge && nextEdge >= EDGE_FIRST_LATE));
   always_comb begin
      if (sample_phase_bit) begin
         mSampleEdge = cke ? (!oddEdge && nextEdge > EDGE_FIRST) :
            (oddEdge && nextEdge >= EDGE_FIRST_LATE);
      end else begin
         mSampleEdge = cke ? oddEdge : (!oddEdge && nextEdge > EDGE_FIRST);
      end
      mSampleEdge = mSampleEdge && halfTick;
   end
   assign mLastEdge = halfTick &&
      (nextEdge == ((sample_phase_bit && !cke) ? EDGE_LATE_LAST : EDGE_SCK_LAST));

   // slave edges from the sampled external clock
   logic sckRise;
   logic sckFall;
   logic leadEdge;
   logic trailEdge;
   logic sOutEdge;
   logic sSampleEdge;
   assign sckRise = pins.sck && !sckPrev_q;
   assign sckFall = !pins.sck && sckPrev_q;
   assign leadEdge = ctrl_q.clock_polarity_bit ? sckFall : sckRise;
   assign trailEdge = ctrl_q.clock_polarity_bit ? sckRise : sckFall;
   assign sOutEdge = slave && !serialReset && (cke ? trailEdge : (leadEdge && bitCount_q != 3'h0));
   assign sSampleEdge = slave && !serialReset && (cke ? leadEdge : trailEdge);
   // reset level matches the synchroniser so no false edge follows reset
   always_ff @(posedge clock) begin
      if (reset) begin
         sckPrev_q <= 1'b1;
         mSampleDly_q <= '0;
      end else if (clkEn) begin
         sckPrev_q <= pins.sck;
         mSampleDly_q <= {mSampleDly_q[SYNC_DEPTH-2:0], mSampleEdge}; // sdi arrives late
      end
   end
   logic sampleNow;
   logic byteDone;
   assign sampleNow = master ? mSampleDly_q[SYNC_DEPTH-1] : sSampleEdge;
   assign byteDone = sampleNow && (bitCount_q == BIT_LAST);
   assign rxNext = {rxShift_q[6:0], pins.sdi};

   // master sequencer
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= SSSP_IDLE;
         edge_q <= 5'h00;
      end else if (clkEn) begin
         case (state_q)
            SSSP_IDLE: begin
               edge_q <= 5'h00;
               if (master && bufWr) begin
                  state_q <= SSSP_SHIFT;
               end
            end
            SSSP_SHIFT: begin
               if (!master) begin
                  state_q <= SSSP_IDLE;
               end else if (mLastEdge) begin
                  state_q <= SSSP_IDLE;
               end else if (halfTick) begin
                  edge_q <= nextEdge;
               end
            end
            default: state_q <= SSSP_IDLE;
         endcase
      end
   end

   // serial clock pin: eight pulses, back to idle level between bytes
   always_ff @(posedge clock) begin
      if (reset) begin
         sckOut <= 1'b0;
         sckOe <= 1'b0;
      end else if (clkEn) begin
         sckOe <= master;
         if (state_q != SSSP_SHIFT) begin
            sckOut <= ctrl_q.clock_polarity_bit;
         end else if (halfTick && nextEdge <= EDGE_SCK_LAST) begin
            sckOut <= !sckOut;
         end
      end
   end

   // shift registers; a buffer write loads the transmit side directly
   always_ff @(posedge clock) begin
      if (reset) begin
         txShift_q <= BYTE_RESET;
         rxShift_q <= BYTE_RESET;
         bitCount_q <= 3'h0;
      end else if (clkEn) begin
         if (bufWr && !busy && enabled) begin
            txShift_q <= regWrData;
         end else if (master ? mOutEdge : sOutEdge) begin
            txShift_q <= {txShift_q[6:0], 1'b0};
         end
         if (bufWr && !busy && master) begin
            rxShift_q <= BYTE_RESET;
         end else if (sampleNow) begin
            rxShift_q <= rxNext;
         end
         if (serialReset || (bufWr && !busy && master)) begin
            bitCount_q <= 3'h0;
         end else if (sampleNow) begin
            bitCount_q <= bitCount_q + 3'h1;
         end
      end
   end

   // data pin drive; select high floats it even mid-byte
   always_ff @(posedge clock) begin
      if (reset) begin
         sdoOut <= 1'b0;
         sdoOe <= 1'b0;
      end else if (clkEn) begin
         sdoOut <= txShift_q[7];
         sdoOe <= !sdoIn_q && (master || (slave && !ssHeld));
      end
   end

   // receive buffer and flags; hardware set beats software clear
   always_ff @(posedge clock) begin
      if (reset) begin
         buffer_q <= BYTE_RESET;
         bufFull_q <= 1'b0;
      end else if (clkEn) begin
         if (byteDone) begin
            buffer_q <= rxNext;
            bufFull_q <= 1'b1;
         end else if (bufWr && !busy) begin
            buffer_q <= regWrData;
         end else if (bufRd) begin
            bufFull_q <= 1'b0;
         end
      end
   end

   // control register with collision and overflow flags
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_q <= CTRL_RESET;
      end else if (clkEn) begin
         if (regWr && regAddr == ADDR_CONTROL_1) begin
            ctrl_q <= sssp_ctrl_t'(regWrData);
         end
         if (collide) begin
            ctrl_q.write_collision_flag <= 1'b1;
         end
         if (byteDone && slave && bufFull_q) begin
            ctrl_q.ovf <= 1'b1; // overflow only arises as a slave
         end
      end
   end

   // status, interrupt flag and enable, pin direction
   always_ff @(posedge clock) begin
      if (reset) begin
         stat_q <= STAT_RESET;
         pif_q <= 1'b0;
         pie_q <= 1'b0;
         sdoIn_q <= 1'b0;
      end else if (clkEn) begin
         if (regWr && regAddr == ADDR_STATUS) begin
            stat_q <= sssp_stat_t'(regWrData[7:6]);
         end
         if (regWr && regAddr == ADDR_IRQ_ENABLES_1) begin
            pie_q <= regWrData[PIE_BIT];
         end
         if (regWr && regAddr == ADDR_PIN_DIR) begin
            sdoIn_q <= regWrData[SDO_IN_BIT];
         end
         if (byteDone) begin
            pif_q <= 1'b1;
         end else if (regWr && regAddr == ADDR_IRQ_FLAGS_1) begin
            pif_q <= regWrData[PIF_BIT];
         end
      end
   end

   // wake request is level; slave path needs no divider so it works asleep
   always_ff @(posedge clock) begin
      if (reset) begin
         wakeOut <= 1'b0;
      end else if (clkEn) begin
         wakeOut <= pif_q && pie_q;
      end
   end

   // read data, valid the cycle after the strobe only
   always_ff @(posedge clock) begin
      if (reset) begin
         regRdData <= 8'h00;
      end else if (clkEn) begin
         regRdData <= 8'h00;
         if (regRd) begin
            case (regAddr)
               ADDR_BUFFER: regRdData <= buffer_q;
               ADDR_CONTROL_1: regRdData <= ctrl_q;
               ADDR_STATUS: regRdData <= {stat_q, 5'h00, bufFull_q};
               ADDR_IRQ_FLAGS_1: regRdData <= 8'(pif_q) << PIF_BIT;
               ADDR_IRQ_ENABLES_1: regRdData <= 8'(pie_q) << PIE_BIT;
               ADDR_PIN_DIR: regRdData <= 8'(sdoIn_q) << SDO_IN_BIT;
               default: regRdData <= 8'h00;
            endcase
         end
      end
   end
endmodule // sssp_core
`default_nettype wire

// *** test/sssp_core_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sssp_core_assertions
   import sssp_pkg::*;
#(
   parameter int unsigned SYNC_DEPTH = 2
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdData,
   input wire logic sleepIn,
   input wire logic sckOut,
   input wire logic sckOe,
   input wire logic sdoOe,
   input wire logic ssNIn,
   input wire logic wakeOut
);
   logic [7:0] ctrlQ;
   logic pieQ;
   logic dirQ;
   logic masterOn;
   logic slvSel;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // shadow of software-owned bits; hardware only ever sets bits 7 and 6
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrlQ <= 8'h00;
         pieQ <= 1'b0;
         dirQ <= 1'b0;
      end else if (regWr && clkEn) begin
         if (regAddr == ADDR_CONTROL_1) ctrlQ <= regWrData;
         if (regAddr == ADDR_IRQ_ENABLES_1) pieQ <= regWrData[PIE_BIT];
         if (regAddr == ADDR_PIN_DIR) dirQ <= regWrData[SDO_IN_BIT];
      end
   end
   // select-driven windows are long enough to cover the synchroniser delay
   assign masterOn = ctrlQ[5] && (ctrlQ[3:0] <= MODE_MASTER_TIMER);
   assign slvSel = ctrlQ[5] && (ctrlQ[3:0] == MODE_SLAVE_SS) && clkEn;
   rd_idle_zero_a:
      assert property (!$past(regRd) |-> regRdData == 8'h00) else $error("stray read data");
   ctrl_readback_a:
      assert property (regRd && clkEn && regAddr == ADDR_CONTROL_1
         |=> regRdData[5:0] == $past(ctrlQ[5:0])) else $error("control readback wrong");
   reset_quiet_a:
      assert property ($past(reset) |-> !sckOe && !sdoOe && !wakeOut) else $error("pins live");
   sck_rate_a:
      assert property ($changed(sckOut) |=> $stable(sckOut)) else $error("sck too fast");
   ss_float_a:
      assert property ((slvSel && ssNIn) [*6] |-> !sdoOe) else $error("sdo driven, ss high");
   ss_drive_a:
      assert property ((slvSel && !ssNIn && !dirQ) [*6] |-> sdoOe) else $error("sdo not driven");
   sdo_input_a:
      assert property (dirQ [*2] |-> !sdoOe) else $error("sdo driven as input");
   slave_sck_in_a:
      assert property ((!masterOn) [*2] |-> !sckOe) else $error("sck driven in slave");
   wake_gate_a:
      assert property (wakeOut |-> $past(pieQ)) else $error("wake while disabled");
   sleep_freeze_a:
      assert property ((sleepIn && masterOn) [*3] |-> $stable(sckOut)) else $error("sck ran");
endmodule // sssp_core_assertions
bind sssp_core sssp_core_assertions #(.SYNC_DEPTH(SYNC_DEPTH)) u_sva (
   .clock(clock), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .sleepIn(sleepIn), .sckOut(sckOut), .sckOe(sckOe), .sdoOe(sdoOe),
   .ssNIn(ssNIn), .wakeOut(wakeOut));
`default_nettype wire

// *** test/sssp_spi_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sssp_spi_slave_model (
   input wire logic sck,
   input wire logic mosi,
   input wire logic clock_polarity_bit,
   input wire logic cke,
   input wire logic load,
   input wire logic [7:0] txByte,
   output logic miso,
   output logic [7:0] rxByte
);
   logic [7:0] sh;
   logic started;
   // always selected, so the reply bit is always driven
   assign miso = sh[7];
   always @(posedge load) begin
      sh = txByte;
      started = 1'b0;
   end
   // edge roles follow polarity and edge bits; no select line to frame bytes
   always @(sck) begin
      if (sck !== clock_polarity_bit) begin
         if (cke) rxByte = {rxByte[6:0], mosi};
         else if (started) sh = sh << 1;
         started = 1'b1;
      end else if (cke) sh = sh << 1;
      else rxByte = {rxByte[6:0], mosi};
   end
endmodule // sssp_spi_slave_model
`default_nettype wire

// *** test/sssp_core_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin errCount++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sssp_core_test
   import sssp_pkg::*;
;
   typedef struct {logic [3:0] m; logic clock_polarity_bit; logic cke; logic sample_phase_bit; logic dir;
      logic [7:0] tx; logic [7:0] sx; int half;} sssp_row_t;
   logic clock, reset, clkEn, regWr, regRd, sleepIn, timerTick, sckIn, sdiIn, ssNIn, sdiW;
   logic sckOut, sckOe, sdoOut, sdoOe, wakeOut, miso, mosi, pLoad, sckPrev, tbMaster;
   logic [2:0] regAddr;
   logic [7:0] regWrData, regRdData, rxByte, pTx, g, v;
   int errCount, nTests, togs, cyc, firstT, lastT, tdiv;
   sssp_row_t r;
   sssp_row_t rows [5] = '{'{MODE_MASTER_DIV4, 0, 1, 0, 0, 8'hA5, 8'h3C, 2},
      '{MODE_MASTER_DIV16, 0, 0, 0, 0, 8'h81, 8'h7E, 8},
      '{MODE_MASTER_DIV64, 1, 1, 1, 0, 8'h5A, 8'hC3, 32},
      '{MODE_MASTER_TIMER, 1, 0, 0, 0, 8'h01, 8'h80, 3},
      '{MODE_MASTER_DIV4, 0, 1, 0, 1, 8'hFF, 8'h96, 2}};
   // a released sdo line toggles, so no stale bit can pass for data
   assign mosi = sdoOe ? sdoOut : clock;
   assign sdiW = tbMaster ? sdiIn : miso;
   sssp_core u_dut (.clock(clock), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .sleepIn(sleepIn), .timerTick(timerTick), .sckIn(sckIn), .sckOut(sckOut),
      .sckOe(sckOe), .sdiIn(sdiW), .sdoOut(sdoOut), .sdoOe(sdoOe), .ssNIn(ssNIn),
      .wakeOut(wakeOut));
   sssp_spi_slave_model u_far (.sck(sckOut), .mosi(mosi), .clock_polarity_bit(r.clock_polarity_bit), .cke(r.cke),
      .load(pLoad), .txByte(pTx), .miso(miso), .rxByte(rxByte));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // companion timer tick every third clock; sck edge counter
   always @(posedge clock) begin
      tdiv <= (tdiv == 2) ? 0 : tdiv + 1;
      timerTick <= (tdiv == 2);
      cyc++;
      if (sckOut !== sckPrev) begin
         if (togs == 0) firstT = cyc;
         togs++;
         lastT = cyc;
      end
      sckPrev = sckOut;
   end
   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [2:0] a);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      @(posedge clock);
      v = regRdData;
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] e);
      rd(a);
      `CHK(v, e)
   endtask
   // poll the flag register under a bounded count
   task automatic waitflag;
      for (int i = 0; i < 600; i++) begin
         rd(ADDR_IRQ_FLAGS_1);
         if (v === 8'h08) break;
      end
      `CHK(v, 8'h08)
   endtask
   task automatic xfer(input logic [7:0] tx, input logic [7:0] sx);
      pTx <= sx;
      pLoad <= 1'b1;
      wr(ADDR_IRQ_FLAGS_1, 8'h00);
      pLoad <= 1'b0;
      togs = 0;
      wr(ADDR_BUFFER, tx);
   endtask
   // bench as slave-side master: 800 ns sck, sample sdo before trailing edge
   task automatic sbyte(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         cycles(2);
         sdiIn <= b[7 - i];
         cycles(2);
         sckIn <= 1'b1;
         cycles(4);
         g = {g[6:0], sdoOut};
         sckIn <= 1'b0;
      end
   endtask
   task automatic report_and_stop;
      $display("tests %0d errors %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      cycles(30000);
      errCount++;
      report_and_stop;
   end
   initial begin
      {clkEn, reset, ssNIn} <= 3'h7;
      {regWr, regRd, sleepIn, sckIn, sdiIn, pLoad, tbMaster} <= 7'h00;
      {regAddr, regWrData, pTx, tdiv} <= '0;
      r = rows[0];
      cycles(10);
      reset <= 1'b0;
      for (int a = 0; a < 8; a++) rc(a[2:0], 8'h00);
      $display("reset values done");
      foreach (rows[i]) begin
         r = rows[i];
         wr(ADDR_CONTROL_1, {3'h1, r.clock_polarity_bit, r.m});
         wr(ADDR_STATUS, {r.sample_phase_bit, r.cke, 6'h00});
         wr(ADDR_PIN_DIR, {7'h00, r.dir});
         xfer(r.tx, r.sx);
         waitflag;
         rc(ADDR_BUFFER, r.sx);
         `CHK(togs, 16)
         `CHK(sckOut, r.clock_polarity_bit)
         `CHK(lastT - firstT, 15 * r.half)
         if (!r.dir) `CHK(rxByte, r.tx)
         $display("row %0d done", i);
      end
      wr(ADDR_IRQ_ENABLES_1, 8'h08);
      cycles(1);
      `CHK(wakeOut, 1'b1)
      wr(ADDR_IRQ_ENABLES_1, 8'h00);
      cycles(1);
      `CHK(wakeOut, 1'b0)
      wr(ADDR_PIN_DIR, 8'h00);
      wr(ADDR_CONTROL_1, 8'h21);
      xfer(8'h11, 8'hE7);
      wr(ADDR_BUFFER, 8'h22);
      rc(ADDR_CONTROL_1, 8'hA1);
      waitflag;
      `CHK(rxByte, 8'h11)
      wr(ADDR_CONTROL_1, 8'h21);
      rc(ADDR_CONTROL_1, 8'h21);
      $display("collision done");
      xfer(8'h4D, 8'hB2);
      cycles(20);
      sleepIn <= 1'b1;
      cycles(40);
      sleepIn <= 1'b0;
      cycles(5);
      clkEn <= 1'b0;
      cycles(10);
      clkEn <= 1'b1;
      waitflag;
      rc(ADDR_BUFFER, 8'hB2);
      `CHK(rxByte, 8'h4D)
      $display("sleep done");
      xfer(8'h0F, 8'hF0);
      cycles(30);
      reset <= 1'b1;
      cycles(10);
      reset <= 1'b0;
      cycles(2);
      `CHK(sckOe, 1'b0)
      rc(ADDR_CONTROL_1, 8'h00);
      $display("abort by reset done");
      tbMaster <= 1'b1;
      wr(ADDR_STATUS, 8'h40);
      wr(ADDR_CONTROL_1, {3'h1, 1'b0, MODE_SLAVE_SS});
      wr(ADDR_BUFFER, 8'hC6);
      wr(ADDR_IRQ_ENABLES_1, 8'h08);
      sleepIn <= 1'b1;
      ssNIn <= 1'b0;
      cycles(8);
      sbyte(8'h3B, 8);
      ssNIn <= 1'b1;
      cycles(10);
      `CHK(wakeOut, 1'b1)
      `CHK(g, 8'hC6)
      sleepIn <= 1'b0;
      rc(ADDR_BUFFER, 8'h3B);
      wr(ADDR_IRQ_FLAGS_1, 8'h00);
      ssNIn <= 1'b0;
      cycles(8);
      sbyte(8'hF0, 3);
      ssNIn <= 1'b1;
      cycles(8);
      `CHK(sdoOe, 1'b0)
      sdiIn <= ~sdiIn;
      ssNIn <= 1'b0;
      cycles(8);
      sbyte(8'h69, 8);
      cycles(10);
      rc(ADDR_IRQ_FLAGS_1, 8'h08);
      rc(ADDR_BUFFER, 8'h69);
      $display("slave select done");
      wr(ADDR_STATUS, 8'h00);
      wr(ADDR_CONTROL_1, {3'h1, 1'b0, MODE_SLAVE_NOSS});
      sbyte(8'hA7, 8);
      cycles(10);
      rc(ADDR_BUFFER, 8'hA7);
      $display("slave without select done");
      report_and_stop;
   end
endmodule // sssp_core_test
`default_nettype wire
